// [hw/acc_pkg.sv]
// Package with register map, field layout and constants of the converter control block
package acc_pkg;
   // Register byte offsets (word aligned)
   localparam logic [3:0] ACC_CTRL_OFS = 4'h0;
   localparam logic [3:0] ACC_CLK_OFS = 4'h4;
   localparam logic [3:0] ACC_RESH_OFS = 4'h8;
   localparam logic [3:0] ACC_RESL_OFS = 4'hC;
   localparam logic [4:0] ACC_IRQ_OFS = 5'h10;
   localparam logic [4:0] ACC_PORT_OFS = 5'h14;
   // Control register fields
   localparam int ACC_START_BIT = 7;
   localparam int ACC_BUSY_BIT = 6;
   localparam int ACC_PCR_LSB = 2;
   localparam int ACC_CH_LSB = 0;
   // Clock register fields
   localparam int ACC_TEST_BIT = 7;
   localparam int ACC_PWROFF_BIT = 6;
   localparam int ACC_CS_LSB = 0;
   // Interrupt register fields
   localparam int ACC_GIE_BIT = 0;
   localparam int ACC_MFIE_BIT = 1;
   localparam int ACC_CIE_BIT = 2;
   localparam int ACC_FLAG_BIT = 3;
   // Reset values
   localparam logic [7:0] ACC_CTRL_RST = 8'h40;
   localparam logic [7:0] ACC_CLK_RST = 8'h80;
   // Conversion length in converter clocks
   localparam int ACC_CONV_CLKS = 16;
   // Least converter clock period and system clock period
   localparam real ACC_TAD_MIN_NS = 0.5 * 1000.0;
   localparam real ACC_SYS_PERIOD_NS = 5.0;
   // Divider reaching the period, rounded up to 101 cycles, one above the least; software's job to pick it
   localparam int ACC_TAD_MIN_CYC = int'((ACC_TAD_MIN_NS + ACC_SYS_PERIOD_NS - 1.0) / ACC_SYS_PERIOD_NS);
   // Clock select codes
   typedef enum logic [2:0] {
      ACC_DIV2 = 3'h0, ACC_DIV8 = 3'h1, ACC_DIV32 = 3'h2, ACC_UND3 = 3'h3,
      ACC_DIV1 = 3'h4, ACC_DIV4 = 3'h5, ACC_DIV16 = 3'h6, ACC_UND7 = 3'h7
   } acc_clksel_t;
   // Result as seen by software
   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } acc_result_t;
endpackage : acc_pkg

// [hw/acc_top.sv]
// Converter control block with classic Wishbone register slave
//
// Decided for this implementation: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - Power-off bit high powers converter down
// - Clock select field picks system clock divider
// - Config bit picks I/O or analog per pin
// - Analog pin loses its pull-high resistor
// - Analog pin overrides port direction setting
// - All config bits zero powers converter down
// - Start low-high-low pulse begins a conversion
// - Conversion lasts sixteen converter clocks
// - Busy falls at end, result readable
// - Interrupt needs three enables, stack not full
// - Result is 12-bit unsigned code
// - Half-step input offset, handled in analog
// - Start high alone resets converter, sets busy
// - Conversion end sets converter interrupt flag
// - Channel field routes input 0..3
// - High holds bits 11..4, low upper nibble
module acc_top
   import acc_pkg::*;
#(
   parameter int NPINS = 4,
   parameter int RES_W = 12
) (
   input wire logic CLOCK_I,
   input wire logic SRST_I,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [7:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   input wire logic STACK_FULL_I,
   input wire logic [RES_W-1:0] SAR_CODE_I,
   input wire logic [NPINS-1:0] PORT_DIR_I,
   input wire logic [NPINS-1:0] PULL_EN_I,
   output logic [NPINS-1:0] PIN_ANALOG_O,
   output logic [NPINS-1:0] PIN_PULL_O,
   output logic [NPINS-1:0] PIN_DIR_O,
   output logic [1:0] INPUT_CHANNEL_O,
   output logic CONV_POWER_ON_O,
   output logic CONV_CLK_EN_O,
   output logic CONV_RESET_O,
   output logic CONV_SAMPLE_O,
   output logic IRQ_O
);

   typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_CONV} acc_state_t;

   acc_state_t state_r;
   logic start_r;
   logic busy_r;
   logic [NPINS-1:0] pin_analog_config_r;
   logic [1:0] input_channel_select_r;
   logic test_r;
   logic converter_power_off_r;
   logic [2:0] conv_clock_select_r;
   logic global_irq_enable_r;
   logic multi_function_irq_enable_r;
   logic converter_irq_enable_r;
   logic converter_irq_flag_r;
   acc_result_t result_r;
   logic [5:0] div_cnt_r;
   logic [4:0] tick_cnt_r;
   logic ack_r;
   logic [31:0] dat_r;

   // Divider ratio minus one for a select code
   function automatic logic [5:0] acc_div_last(input logic [2:0] sel);
      unique case (sel)
         ACC_DIV1: acc_div_last = 6'h00;
         ACC_DIV2: acc_div_last = 6'h01;
         ACC_DIV4: acc_div_last = 6'h03;
         ACC_DIV8: acc_div_last = 6'h07;
         ACC_DIV16: acc_div_last = 6'h0F;
         ACC_DIV32: acc_div_last = 6'h1F;
         default: acc_div_last = 6'h1F;
      endcase
   endfunction : acc_div_last

   // Bus decode
   logic bus_req;
   logic bus_wr;
   logic wr_ctrl;
   logic wr_clk;
   logic wr_irq;
   logic powered;
   logic tad_tick;
   logic conv_done;
   logic start_wr_val;
   assign bus_req = CYC_I && STB_I && !ack_r;
   // Writes land at the edge where ack is seen high
   assign bus_wr = CYC_I && STB_I && WE_I && ack_r;
   assign wr_ctrl = bus_wr && SEL_I[0] && (ADR_I == {4'h0, ACC_CTRL_OFS});
   assign wr_clk = bus_wr && SEL_I[0] && (ADR_I == {4'h0, ACC_CLK_OFS});
   assign wr_irq = bus_wr && SEL_I[0] && (ADR_I == {3'h0, ACC_IRQ_OFS});
   assign start_wr_val = DAT_I[ACC_START_BIT];
   // Converter is powered only when enabled and a pin is analog
   assign powered = !converter_power_off_r && (|pin_analog_config_r);
   // Undefined codes never tick
   assign tad_tick = powered && (div_cnt_r == acc_div_last(conv_clock_select_r)) &&
                     (conv_clock_select_r != ACC_UND3) && (conv_clock_select_r != ACC_UND7);
   assign conv_done = (state_r == ST_CONV) && tad_tick && (tick_cnt_r == 5'(ACC_CONV_CLKS - 1));

   // Wishbone acknowledge, one cycle after request
   // A master that drops its strobe before ack leaves the registers untouched
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= bus_req;
      end
   end

   // Read data mux, unmapped reads return zero
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         dat_r <= 32'h0000_0000;
      end else if (bus_req && !WE_I) begin
         unique case (ADR_I)
            {4'h0, ACC_CTRL_OFS}: dat_r <= {24'h0, start_r, busy_r, pin_analog_config_r, input_channel_select_r};
            {4'h0, ACC_CLK_OFS}: dat_r <= {24'h0, test_r, converter_power_off_r, 3'h0, conv_clock_select_r};
            {4'h0, ACC_RESH_OFS}: dat_r <= {24'h0, result_r.high};
            {4'h0, ACC_RESL_OFS}: dat_r <= {24'h0, result_r.low};
            {3'h0, ACC_IRQ_OFS}: dat_r <= {28'h0, converter_irq_flag_r, converter_irq_enable_r,
                                           multi_function_irq_enable_r, global_irq_enable_r};
            {3'h0, ACC_PORT_OFS}: dat_r <= {28'h0, pin_analog_config_r};
            default: dat_r <= 32'h0000_0000;
         endcase
      end
   end

   // Control register fields
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         start_r <= ACC_CTRL_RST[ACC_START_BIT];
         pin_analog_config_r <= ACC_CTRL_RST[ACC_PCR_LSB +: 4];
         input_channel_select_r <= ACC_CTRL_RST[ACC_CH_LSB +: 2];
      end else if (wr_ctrl) begin
         start_r <= start_wr_val;
         pin_analog_config_r <= DAT_I[ACC_PCR_LSB +: 4];
         input_channel_select_r <= DAT_I[ACC_CH_LSB +: 2];
      end
   end

   // Clock register fields
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         test_r <= ACC_CLK_RST[ACC_TEST_BIT];
         converter_power_off_r <= ACC_CLK_RST[ACC_PWROFF_BIT];
         conv_clock_select_r <= ACC_CLK_RST[ACC_CS_LSB +: 3];
      end else if (wr_clk) begin
         test_r <= DAT_I[ACC_TEST_BIT];
         converter_power_off_r <= DAT_I[ACC_PWROFF_BIT];
         conv_clock_select_r <= DAT_I[ACC_CS_LSB +: 3];
      end
   end

   // Interrupt enables
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         global_irq_enable_r <= 1'b0;
         multi_function_irq_enable_r <= 1'b0;
         converter_irq_enable_r <= 1'b0;
      end else if (wr_irq) begin
         global_irq_enable_r <= DAT_I[ACC_GIE_BIT];
         multi_function_irq_enable_r <= DAT_I[ACC_MFIE_BIT];
         converter_irq_enable_r <= DAT_I[ACC_CIE_BIT];
      end
   end

   // Sticky flag, write one to clear, set wins
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         converter_irq_flag_r <= 1'b0;
      end else if (conv_done) begin
         converter_irq_flag_r <= 1'b1;
      end else if (wr_irq && DAT_I[ACC_FLAG_BIT]) begin
         converter_irq_flag_r <= 1'b0;
      end
   end

   // Start pulse sequencer
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         state_r <= ST_IDLE;
      end else if (wr_ctrl && start_wr_val && !start_r) begin
         state_r <= ST_ARMED;
      end else if (wr_ctrl && !start_wr_val && start_r) begin
         state_r <= ST_CONV;
      end else if (conv_done || !powered) begin
         state_r <= ST_IDLE;
      end
   end

   // Busy flag
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         busy_r <= ACC_CTRL_RST[ACC_BUSY_BIT];
      end else if (wr_ctrl && start_wr_val && !start_r) begin
         busy_r <= 1'b1;
      end else if (conv_done) begin
         busy_r <= 1'b0;
      end
   end

   // Converter clock divider, restarted with each conversion
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         div_cnt_r <= 6'h00;
      end else if (state_r != ST_CONV || tad_tick || !powered) begin
         div_cnt_r <= 6'h00;
      end else begin
         div_cnt_r <= div_cnt_r + 6'h01;
      end
   end

   // Converter clock count per conversion
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         tick_cnt_r <= 5'h00;
      end else if (state_r != ST_CONV) begin
         tick_cnt_r <= 5'h00;
      end else if (tad_tick) begin
         tick_cnt_r <= tick_cnt_r + 5'h01;
      end
   end

   // Result capture, both bytes in one edge
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         result_r <= '0;
      end else if (conv_done) begin
         // Half-step input offset lives in the analog path; code taken as is
         result_r.high <= SAR_CODE_I[RES_W-1 -: 8];
         result_r.low <= {SAR_CODE_I[3:0], 4'h0};
      end
   end

   // Registered outputs
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         PIN_ANALOG_O <= '0;
         PIN_PULL_O <= '0;
         PIN_DIR_O <= '0;
         INPUT_CHANNEL_O <= 2'h0;
         CONV_POWER_ON_O <= 1'b0;
         CONV_CLK_EN_O <= 1'b0;
         CONV_RESET_O <= 1'b1;
         CONV_SAMPLE_O <= 1'b0;
         IRQ_O <= 1'b0;
      end else begin
         PIN_ANALOG_O <= pin_analog_config_r;
         PIN_PULL_O <= PULL_EN_I & ~pin_analog_config_r;
         PIN_DIR_O <= PORT_DIR_I | pin_analog_config_r;
         INPUT_CHANNEL_O <= input_channel_select_r;
         CONV_POWER_ON_O <= powered;
         CONV_CLK_EN_O <= tad_tick && (state_r == ST_CONV);
         CONV_RESET_O <= (state_r != ST_CONV);
         CONV_SAMPLE_O <= conv_done;
         IRQ_O <= global_irq_enable_r && multi_function_irq_enable_r && converter_irq_enable_r &&
                  converter_irq_flag_r && !STACK_FULL_I;
      end
   end

   assign ACK_O = ack_r;
   assign DAT_O = dat_r;

   // Assertions
   sequence s_conv_start;
      wr_ctrl && !start_wr_val && start_r;
   endsequence

   // Start with the undivided clock, one tick per system cycle
   sequence s_div1_start;
      s_conv_start ##0 (powered && conv_clock_select_r == ACC_DIV1);
   endsequence

   a_busy_on_arm: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      (wr_ctrl && start_wr_val && !start_r) |=> busy_r && state_r == ST_ARMED)
      else $error("busy not set on start rise");
   a_start_enters_conv: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      s_conv_start |=> state_r == ST_CONV)
      else $error("conversion did not start");
   a_done_clears_busy: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      conv_done && !wr_ctrl |=> !busy_r)
      else $error("busy not cleared at end");
   a_done_sets_flag: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      conv_done |=> converter_irq_flag_r)
      else $error("flag not set at end");
   a_sixteen_ticks: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      s_div1_start |-> ##16 (conv_done || state_r != ST_CONV || conv_clock_select_r != ACC_DIV1))
      else $error("conversion length wrong");
   a_power_gate: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      (converter_power_off_r || pin_analog_config_r == '0) |=> !CONV_POWER_ON_O)
      else $error("converter powered while off");
   a_pull_cut: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      ##1 (PIN_PULL_O & $past(pin_analog_config_r)) == '0)
      else $error("pull-high on analog pin");
   a_dir_override: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      ##1 (PIN_DIR_O & $past(pin_analog_config_r)) == $past(pin_analog_config_r))
      else $error("direction not overridden");
   a_irq_gate: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      IRQ_O |-> $past(global_irq_enable_r && multi_function_irq_enable_r && converter_irq_enable_r &&
                      converter_irq_flag_r && !STACK_FULL_I))
      else $error("interrupt without enables");
   a_result_pair: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      conv_done |=> result_r.low == {$past(SAR_CODE_I[3:0]), 4'h0} && result_r.high == $past(SAR_CODE_I[11:4]))
      else $error("result bytes not captured together");

   // Flag, result, sequencer and pin checks
   a_flag_w1c: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      (wr_irq && DAT_I[ACC_FLAG_BIT] && !conv_done) |=> !converter_irq_flag_r)
      else $error("flag not cleared by write");
   a_result_hold: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      !conv_done |=> $stable(result_r))
      else $error("result changed outside end");
   a_busy_armed: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      state_r == ST_ARMED |-> busy_r)
      else $error("armed without busy");
   a_armed_reset: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      state_r == ST_ARMED |=> CONV_RESET_O)
      else $error("converter not held in reset");
   a_tick_in_conv: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      CONV_CLK_EN_O |-> $past(state_r == ST_CONV))
      else $error("converter clock outside conversion");
   a_sample_at_end: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      conv_done |=> CONV_SAMPLE_O)
      else $error("no sample pulse at end");
   a_irq_delivery: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      (global_irq_enable_r && multi_function_irq_enable_r && converter_irq_enable_r &&
       converter_irq_flag_r && !STACK_FULL_I) |=> IRQ_O)
      else $error("interrupt not delivered");
   a_chan_route: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      ##1 (INPUT_CHANNEL_O == $past(input_channel_select_r)))
      else $error("channel not routed");
   a_pin_mode: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
      ##1 (PIN_ANALOG_O == $past(pin_analog_config_r)))
      else $error("pin mode not applied");

endmodule : acc_top

// [tb/acc_partner.sv]
// Analog source model standing in front of the converter input
`timescale 1ns/1ps
module acc_partner
   import acc_pkg::*;
(
   input wire logic power_on_i,
   input wire logic [11:0] level_i,
   output logic [11:0] code_o
);
   // Unpowered converter gives no valid code, so show the inverse
   always_comb begin
      code_o = power_on_i ? level_i : ~level_i;
   end
endmodule : acc_partner

// [tb/acc_top_bench.sv]
// Register-level bench for the converter control block
`timescale 1ns/1ps
module acc_top_bench
   import acc_pkg::*;
;
   localparam logic [7:0] A_CTRL = 8'(ACC_CTRL_OFS);
   localparam logic [7:0] A_CLK = 8'(ACC_CLK_OFS);
   localparam logic [7:0] A_IRQ = 8'(ACC_IRQ_OFS);
   logic clk, srst, cyc, stb, we, ack, irq, stk, pwr, cke, crst, samp;
   logic [7:0] adr;
   logic [3:0] sel, pdir, pull, ana, ppull, pdir_o;
   logic [31:0] dat_i, dat_o;
   logic [11:0] sar, level;
   logic [1:0] chan;
   int n_fail, n_checks, cyc_cnt, ticks, gap, since, n_samp;
   int div_of [8] = '{2, 8, 32, 0, 1, 4, 16, 0};

   acc_top acc_top_inst (.CLOCK_I(clk), .SRST_I(srst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
      .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_i), .DAT_O(dat_o), .ACK_O(ack), .STACK_FULL_I(stk),
      .SAR_CODE_I(sar), .PORT_DIR_I(pdir), .PULL_EN_I(pull), .PIN_ANALOG_O(ana),
      .PIN_PULL_O(ppull), .PIN_DIR_O(pdir_o), .INPUT_CHANNEL_O(chan), .CONV_POWER_ON_O(pwr),
      .CONV_CLK_EN_O(cke), .CONV_RESET_O(crst), .CONV_SAMPLE_O(samp), .IRQ_O(irq));
   acc_partner acc_partner_inst (.power_on_i(pwr), .level_i(level), .code_o(sar));

   // Clock generation
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Tick and sample counting, tick spacing and hang guard
   always @(posedge clk) begin
      cyc_cnt++;
      if (samp === 1'b1) n_samp++;
      if (cke === 1'b1) begin
         ticks++;
         gap = since;
         since = 1;
      end else begin
         since++;
      end
      if (cyc_cnt == 20000) begin
         n_fail++;
         finish_test();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk

   // Classic single Wishbone cycle, waits for ack
   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                     output logic [31:0] q);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_i <= {24'h0, d};
      sel <= s;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge clk);
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, 4'hF, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      logic [31:0] q;
      wb(1'b0, a, 8'h00, 4'hF, q);
      chk(q, {24'h0, e});
   endtask : rd

   // One full conversion with a given clock code and input level
   task automatic convert(input logic [2:0] cs, input logic [11:0] lv);
      logic [31:0] q;
      int t0, s0;
      level <= lv;
      wr(A_IRQ, 8'h08);
      wr(A_CLK, {5'h0, cs});
      wr(A_CTRL, 8'h04);
      wr(A_CTRL, 8'h84);
      rd(A_CTRL, 8'hC4);
      chk(crst, 1);
      t0 = ticks;
      s0 = n_samp;
      wr(A_CTRL, 8'h04);
      @(posedge clk);
      chk(crst, 0);
      do begin
         wb(1'b0, A_CTRL, 8'h00, 4'hF, q);
      end while (q[ACC_BUSY_BIT] !== 1'b0);
      chk(q, 32'h04);
      chk(n_samp - s0, 1);
      chk(ticks - t0, ACC_CONV_CLKS);
      chk(gap, div_of[cs]);
      rd(8'(ACC_RESH_OFS), lv[11:4]);
      rd(8'(ACC_RESL_OFS), {lv[3:0], 4'h0});
      rd(A_IRQ, 8'h08);
   endtask : convert

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   // Main test sequence
   initial begin
      logic [31:0] q;
      {cyc, stb, we, stk, adr, sel, dat_i} = '0;
      srst = 1'b1;
      pdir = 4'h6;
      pull = 4'hB;
      level = 12'h000;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      rd(A_CTRL, ACC_CTRL_RST);
      rd(A_CLK, ACC_CLK_RST);
      rd(A_IRQ, 8'h00);
      wr(8'h20, 8'hFF);
      rd(8'h20, 8'h00);
      wb(1'b1, A_CTRL, 8'h3F, 4'hE, q);
      rd(A_CTRL, ACC_CTRL_RST);
      $display("test registers done");
      for (int c = 0; c < 4; c++) begin
         wr(A_CTRL, {2'b00, 4'(1 << c), 2'(c)});
         repeat (2) @(posedge clk);
         chk(ana, 1 << c);
         chk(ppull, 4'hB & ~(4'(1 << c)));
         chk(pdir_o, 4'h6 | 4'(1 << c));
         chk(chan, c);
         chk(pwr, 1);
      end
      wr(A_CLK, 8'h40);
      repeat (2) @(posedge clk);
      chk(pwr, 0);
      wr(A_CLK, 8'h00);
      wr(A_CTRL, 8'h00);
      repeat (2) @(posedge clk);
      chk(pwr, 0);
      chk(ppull, 4'hB);
      chk(pdir_o, 4'h6);
      chk(ana, 0);
      $display("test pins done");
      // Software would keep ACC_TAD_MIN_CYC cycles per tick; faster codes here exercise logic only
      for (int i = 0; i < 7; i++) begin
         if (i != 3) convert(3'(i), (i == 6) ? 12'hFFF : 12'h5A3 + 12'(i));
      end
      $display("test conversions done");
      wr(A_IRQ, 8'h07);
      repeat (2) @(posedge clk);
      chk(irq, 1);
      stk <= 1'b1;
      repeat (2) @(posedge clk);
      chk(irq, 0);
      stk <= 1'b0;
      for (int b = 0; b < 3; b++) begin
         wr(A_IRQ, 8'h07 & ~(8'(1 << b)));
         repeat (2) @(posedge clk);
         chk(irq, 0);
      end
      wr(A_IRQ, 8'h0F);
      repeat (2) @(posedge clk);
      chk(irq, 0);
      rd(A_IRQ, 8'h07);
      $display("test interrupt done");
      finish_test();
   end
endmodule : acc_top_bench
